/* File: rtl/sad_pkg.sv */
// constants and types shared by the command decoder, its assertions, the execution model and the bench
// assumes one 250 MHz clock domain for the whole block
package sad_pkg;

  localparam int BYTE_W = 8;
  localparam int LEN_W = 9;
  localparam int FIFO_DEPTH = 32;
  localparam int HDR_BYTES = 5;
  localparam logic [2:0] HDR_LAST = 3'h4;
  localparam logic [LEN_W-1:0] LEN_MAX = 9'h100;

  // class byte that addresses this application
  localparam logic [7:0] CLA_APP = 8'hA0;

  // instruction codes
  localparam logic [7:0] INS_SELECT = 8'hA4;
  localparam logic [7:0] INS_STATUS = 8'hF2;
  localparam logic [7:0] INS_READ_BIN = 8'hB0;
  localparam logic [7:0] INS_UPD_BIN = 8'hD6;
  localparam logic [7:0] INS_READ_REC = 8'hB2;
  localparam logic [7:0] INS_UPD_REC = 8'hDC;
  localparam logic [7:0] INS_SEEK = 8'hA2;
  localparam logic [7:0] INS_INCREASE = 8'h32;
  localparam logic [7:0] INS_VERIFY = 8'h20;
  localparam logic [7:0] INS_CHANGE = 8'h24;
  localparam logic [7:0] INS_DISABLE = 8'h26;
  localparam logic [7:0] INS_ENABLE = 8'h28;
  localparam logic [7:0] INS_UNLOCK = 8'h2C;
  localparam logic [7:0] INS_FILE_DIS = 8'h04;
  localparam logic [7:0] INS_FILE_RST = 8'h44;
  localparam logic [7:0] INS_AUTH = 8'h88;
  localparam logic [7:0] INS_IDLE = 8'hFA;
  localparam logic [7:0] INS_FETCH = 8'hC0;

  // fixed parameter values
  localparam logic [7:0] PAR_ZERO = 8'h00;
  localparam logic [7:0] PAR_ONE = 8'h01;
  localparam logic [7:0] PAR_CODE2 = 8'h02;
  localparam logic [7:0] LEN_SELECT = 8'h02;
  localparam logic [7:0] LEN_INCREASE = 8'h03;
  localparam logic [7:0] LEN_CODE = 8'h08;
  localparam logic [7:0] LEN_CODE2X = 8'h10;

  // status words
  localparam logic [7:0] SW1_PENDING = 8'h9F;
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_ERR_CLA = 16'h6E00;
  localparam logic [15:0] SW_ERR_INS = 16'h6D00;
  localparam logic [15:0] SW_ERR_PAR = 16'h6B00;
  localparam logic [15:0] SW_ERR_LEN = 16'h6700;
  localparam logic [15:0] SW_ERR_NODATA = 16'h6F00;

  typedef struct packed {
    logic [7:0] cla;
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
  } sad_hdr_t;

  typedef struct packed {
    logic [7:0] sw1;
    logic [7:0] sw2;
  } sad_sw_t;

  // what the decoder hands to the execution side
  typedef struct packed {
    sad_hdr_t hdr;
    logic [15:0] offset;
    logic [LEN_W-1:0] len;
    logic data_in;
    logic data_out;
  } sad_cmd_t;

  typedef enum {
    ST_HDR,
    ST_CHK,
    ST_RXD,
    ST_OUTD,
    ST_WDONE,
    ST_SW1,
    ST_SW2
  } sad_st_t;

endpackage

/* File: rtl/sad_fifo.sv */
// byte buffer with valid/ready on both sides and a fill level
// assumes a single clock; drain side may stall freely
`timescale 1ns/1ps
module sad_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [$clog2(D):0] level_o
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } sad_fifo_st_t;

  sad_fifo_st_t s_r;
  sad_fifo_st_t s_nxt;
  logic push;
  logic pop;

  assign in_ready_o = (s_r.cnt != D[AW:0]);
  assign out_valid_o = (s_r.cnt != '0);
  assign out_data_o = s_r.mem[s_r.rd];
  assign level_o = s_r.cnt;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr] = in_data_i;
      s_nxt.wr = s_r.wr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd = s_r.rd + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

/* File: rtl/sad_top.sv */
// command unit decoder of the subscriber card application
// assumes the character layer and the execution unit share REF_CLK_I
//
// Behaviour
// - five header bytes, data, then two status
// - class A0 addresses this application
// - FF accepted only in parameter bytes that are not fixed
// - outgoing length 00 means 256 bytes
// - incoming length 00 means no data
// - unknown length answered 9F plus length
// - foreign class leaves application state alone
// - offset is P1 high, P2 low
// - reserved instruction codes are never executed
// - select: A4, 00 00 02, may respond
// - status query: F2, parameters zero
// - binary read B0, binary write D6
// - record read B2, record write DC
// - search: A2, P1 00, may respond
// - add: 32, 00 00 03, responds
// - verify 20 len 08, change 24 len 10
// - disable 26, enable 28: 00 01 08
// - unlock 2C len 10, P2 00 or 02
// - file restore 44, all zero, no data
// - authenticate 88, 00 00 10, responds
// - idle FA, all zero, no data
// - status query data laid out as select
`timescale 1ns/1ps
module sad_top (
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_VALID_I,
  output logic RX_READY_O,
  output logic [7:0] TX_DATA_O,
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  output logic EXEC_START_O,
  output sad_pkg::sad_cmd_t EXEC_CMD_O,
  output logic [7:0] EXEC_DIN_O,
  output logic EXEC_DIN_VALID_O,
  input wire logic [7:0] EXEC_RSP_I,
  input wire logic EXEC_RSP_VALID_I,
  output logic EXEC_RSP_READY_O,
  input wire logic EXEC_DONE_I,
  input wire sad_pkg::sad_sw_t EXEC_SW_I,
  input wire logic [7:0] EXEC_RLEN_I,
  output logic PENDING_O,
  output logic [7:0] PEND_LEN_O
);

  import sad_pkg::*;

  // decoded shape of an instruction
  typedef struct packed {
    logic known;
    logic din;
    logic dout;
    logic dunk;
    logic chk_p1;
    logic chk_p2;
    logic [7:0] p2_val;
    logic chk_p3;
    logic [7:0] p3_val;
  } sad_dec_t;

  typedef struct packed {
    sad_st_t st;
    sad_hdr_t hdr;
    logic [2:0] idx;
    logic [LEN_W-1:0] cnt;
    logic [LEN_W-1:0] len;
    sad_dec_t dec;
    logic pend;
    logic [7:0] pend_len;
    sad_sw_t sw;
    logic rx_ready;
    logic rsp_ready;
    logic start;
    sad_cmd_t cmd;
    logic [7:0] din;
    logic din_valid;
    logic tx_valid;
    logic [7:0] tx_data;
  } sad_state_t;

  sad_state_t s_r;
  sad_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // instruction table

  function automatic sad_dec_t decode(input logic [7:0] ins);
    sad_dec_t d;
    d = '0;
    d.known = 1'b1;
    unique case (ins)
      INS_SELECT: begin
        d.din = 1'b1;
        d.dunk = 1'b1;
        d.chk_p1 = 1'b1;
        d.chk_p2 = 1'b1;
        d.chk_p3 = 1'b1;
        d.p3_val = LEN_SELECT;
      end
      INS_STATUS: begin
        d.dout = 1'b1;
        d.chk_p1 = 1'b1;
        d.chk_p2 = 1'b1;
      end
      INS_READ_BIN, INS_READ_REC: begin
        d.dout = 1'b1;
      end
      INS_UPD_BIN, INS_UPD_REC: begin
        d.din = 1'b1;
      end
      INS_SEEK: begin
        d.din = 1'b1;
        d.dunk = 1'b1;
        d.chk_p1 = 1'b1;
      end
      INS_INCREASE: begin
        d.din = 1'b1;
        d.dunk = 1'b1;
        d.chk_p1 = 1'b1;
        d.chk_p2 = 1'b1;
        d.chk_p3 = 1'b1;
        d.p3_val = LEN_INCREASE;
      end
      INS_VERIFY: begin
        d.din = 1'b1;
        d.chk_p1 = 1'b1;
        d.chk_p3 = 1'b1;
        d.p3_val = LEN_CODE;
      end
      INS_CHANGE: begin
        d.din = 1'b1;
        d.chk_p1 = 1'b1;
        d.chk_p3 = 1'b1;
        d.p3_val = LEN_CODE2X;
      end
      INS_DISABLE, INS_ENABLE: begin
        d.din = 1'b1;
        d.chk_p1 = 1'b1;
        d.chk_p2 = 1'b1;
        d.p2_val = PAR_ONE;
        d.chk_p3 = 1'b1;
        d.p3_val = LEN_CODE;
      end
      INS_UNLOCK: begin
        // second parameter range checked separately
        d.din = 1'b1;
        d.chk_p1 = 1'b1;
        d.chk_p3 = 1'b1;
        d.p3_val = LEN_CODE2X;
      end
      INS_FILE_DIS, INS_FILE_RST, INS_IDLE: begin
        d.chk_p1 = 1'b1;
        d.chk_p2 = 1'b1;
        d.chk_p3 = 1'b1;
      end
      INS_AUTH: begin
        d.din = 1'b1;
        d.dunk = 1'b1;
        d.chk_p1 = 1'b1;
        d.chk_p2 = 1'b1;
        d.chk_p3 = 1'b1;
        d.p3_val = LEN_CODE2X;
      end
      INS_FETCH: begin
        d.dout = 1'b1;
        d.chk_p1 = 1'b1;
        d.chk_p2 = 1'b1;
      end
      // reserved and undefined codes all land here
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // response buffer

  logic [7:0] fifo_in;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_out;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic rx_take;
  logic rsp_take;
  logic params_ok;
  logic p3_ok;

  sad_fifo #(
    .W(BYTE_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(REF_CLK_I),
    .arst_n_i(ARST_N_I),
    .in_data_i(fifo_in),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .level_o(fifo_level)
  );

  assign rx_take = RX_VALID_I && s_r.rx_ready;
  assign rsp_take = EXEC_RSP_VALID_I && s_r.rsp_ready;
  assign fifo_out_ready = !s_r.tx_valid || TX_READY_I;

  // 'FF' is never singled out: only the fixed fields are compared
  assign params_ok = (!s_r.dec.chk_p1 || s_r.hdr.p1 == PAR_ZERO) &&
    (!s_r.dec.chk_p2 || s_r.hdr.p2 == s_r.dec.p2_val) &&
    (s_r.hdr.ins != INS_UNLOCK || s_r.hdr.p2 == PAR_ZERO ||
     s_r.hdr.p2 == PAR_CODE2);
  assign p3_ok = !s_r.dec.chk_p3 || s_r.hdr.p3 == s_r.dec.p3_val;

  always_comb begin
    fifo_in = EXEC_RSP_I;
    fifo_in_valid = 1'b0;
    unique case (s_r.st)
      ST_OUTD: begin
        fifo_in_valid = rsp_take;
      end
      ST_SW1: begin
        fifo_in = s_r.sw.sw1;
        fifo_in_valid = 1'b1;
      end
      ST_SW2: begin
        fifo_in = s_r.sw.sw2;
        fifo_in_valid = 1'b1;
      end
      default: begin
        fifo_in_valid = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer

  always_comb begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.din_valid = 1'b0;
    if (fifo_out_ready) begin
      s_nxt.tx_valid = fifo_out_valid;
      s_nxt.tx_data = fifo_out;
    end
    unique case (s_r.st)
      ST_HDR: begin
        if (rx_take) begin
          unique case (s_r.idx)
            3'h0: s_nxt.hdr.cla = RX_DATA_I;
            3'h1: s_nxt.hdr.ins = RX_DATA_I;
            3'h2: s_nxt.hdr.p1 = RX_DATA_I;
            3'h3: s_nxt.hdr.p2 = RX_DATA_I;
            default: s_nxt.hdr.p3 = RX_DATA_I;
          endcase
          s_nxt.idx = s_r.idx + 3'h1;
          if (s_r.idx == HDR_LAST) begin
            s_nxt.st = ST_CHK;
            s_nxt.idx = 3'h0;
            s_nxt.dec = decode(s_r.hdr.ins);
          end
        end
      end
      ST_CHK: begin
        if (s_r.dec.dout) begin
          s_nxt.len = (s_r.hdr.p3 == PAR_ZERO) ? LEN_MAX :
            {1'b0, s_r.hdr.p3};
        end else begin
          s_nxt.len = {1'b0, s_r.hdr.p3};
        end
        s_nxt.cnt = '0;
        s_nxt.st = ST_SW1;
        if (s_r.hdr.cla != CLA_APP) begin
          // pending data survives a foreign command
          s_nxt.sw = SW_ERR_CLA;
        end else if (!s_r.dec.known) begin
          s_nxt.sw = SW_ERR_INS;
        end else if (!params_ok) begin
          s_nxt.sw = SW_ERR_PAR;
        end else if (!p3_ok) begin
          s_nxt.sw = SW_ERR_LEN;
        end else if (s_r.hdr.ins == INS_FETCH && !s_r.pend) begin
          s_nxt.sw = SW_ERR_NODATA;
        end else if (s_r.hdr.ins == INS_FETCH &&
                     s_nxt.len > {1'b0, s_r.pend_len}) begin
          // length 00 asks for 256, always more than can be pending
          s_nxt.sw = SW_ERR_LEN;
        end else begin
          s_nxt.start = 1'b1;
          s_nxt.cmd.hdr = s_r.hdr;
          s_nxt.cmd.offset = {s_r.hdr.p1, s_r.hdr.p2};
          s_nxt.cmd.len = s_nxt.len;
          s_nxt.cmd.data_in = s_r.dec.din;
          s_nxt.cmd.data_out = s_r.dec.dout;
          // any accepted command consumes the pending data
          s_nxt.pend = 1'b0;
          s_nxt.pend_len = '0;
          if (s_r.dec.din && s_r.hdr.p3 != PAR_ZERO) begin
            s_nxt.st = ST_RXD;
          end else if (s_r.dec.dout) begin
            s_nxt.st = ST_OUTD;
          end else begin
            s_nxt.st = ST_WDONE;
          end
        end
      end
      ST_RXD: begin
        if (rx_take) begin
          s_nxt.din = RX_DATA_I;
          s_nxt.din_valid = 1'b1;
          s_nxt.cnt = s_r.cnt + 9'h001;
          if (s_nxt.cnt == s_r.len) begin
            s_nxt.st = ST_WDONE;
          end
        end
      end
      ST_OUTD: begin
        if (rsp_take) begin
          s_nxt.cnt = s_r.cnt + 9'h001;
          if (s_nxt.cnt == s_r.len) begin
            s_nxt.st = ST_WDONE;
          end
        end
      end
      ST_WDONE: begin
        if (EXEC_DONE_I) begin
          s_nxt.st = ST_SW1;
          if (s_r.dec.dunk && EXEC_SW_I == SW_OK &&
              EXEC_RLEN_I != PAR_ZERO) begin
            s_nxt.sw.sw1 = SW1_PENDING;
            s_nxt.sw.sw2 = EXEC_RLEN_I;
            s_nxt.pend = 1'b1;
            s_nxt.pend_len = EXEC_RLEN_I;
          end else begin
            // error statuses from execution go out unchanged
            s_nxt.sw = EXEC_SW_I;
          end
        end
      end
      ST_SW1: begin
        if (fifo_in_ready) begin
          s_nxt.st = ST_SW2;
        end
      end
      ST_SW2: begin
        if (fifo_in_ready) begin
          s_nxt.st = ST_HDR;
        end
      end
    endcase
    // registered ready needs one free slot beyond this cycle's push
    s_nxt.rx_ready = (s_nxt.st == ST_HDR) || (s_nxt.st == ST_RXD);
    s_nxt.rsp_ready = (s_nxt.st == ST_OUTD) &&
      ({1'b0, fifo_level} + {6'h00, fifo_in_valid && fifo_in_ready} <
       FIFO_DEPTH[6:0]);
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s_r <= '0;
      s_r.st <= ST_HDR;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RX_READY_O = s_r.rx_ready;
  assign TX_DATA_O = s_r.tx_data;
  assign TX_VALID_O = s_r.tx_valid;
  assign EXEC_START_O = s_r.start;
  assign EXEC_CMD_O = s_r.cmd;
  assign EXEC_DIN_O = s_r.din;
  assign EXEC_DIN_VALID_O = s_r.din_valid;
  assign EXEC_RSP_READY_O = s_r.rsp_ready;
  assign PENDING_O = s_r.pend;
  assign PEND_LEN_O = s_r.pend_len;

endmodule

/* File: sim/sad_top_sva.sv */
// port-level assertions for the command decoder
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/1ps
module sad_top_sva
  import sad_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic RX_VALID_I,
  input wire logic RX_READY_O,
  input wire logic [7:0] TX_DATA_O,
  input wire logic TX_VALID_O,
  input wire logic TX_READY_I,
  input wire logic EXEC_START_O,
  input wire sad_cmd_t EXEC_CMD_O,
  input wire logic EXEC_DIN_VALID_O,
  input wire logic EXEC_RSP_READY_O,
  input wire logic PENDING_O,
  input wire logic [7:0] PEND_LEN_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  start_pulse_a: assert property (EXEC_START_O |=> !EXEC_START_O)
    else $error("start pulse longer than one cycle");
  class_gate_a: assert property (
    EXEC_START_O |-> EXEC_CMD_O.hdr.cla == CLA_APP)
    else $error("command started with a foreign class");
  offset_join_a: assert property (
    EXEC_START_O |-> EXEC_CMD_O.offset ==
      {EXEC_CMD_O.hdr.p1, EXEC_CMD_O.hdr.p2})
    else $error("offset not p1 high p2 low");
  out_len_a: assert property (
    EXEC_START_O && EXEC_CMD_O.data_out && EXEC_CMD_O.hdr.p3 == 8'h00
      |-> EXEC_CMD_O.len == LEN_MAX)
    else $error("outgoing length zero not 256");
  in_len_a: assert property (
    EXEC_START_O && EXEC_CMD_O.data_in
      |-> EXEC_CMD_O.len == {1'b0, EXEC_CMD_O.hdr.p3})
    else $error("incoming length differs from p3");
  din_take_a: assert property (
    EXEC_DIN_VALID_O |-> $past(RX_VALID_I && RX_READY_O)
      && EXEC_CMD_O.data_in)
    else $error("data byte passed on without a take");
  rsp_dir_a: assert property (
    EXEC_RSP_READY_O |-> EXEC_CMD_O.data_out)
    else $error("response fetched for inbound command");
  tx_hold_a: assert property (
    TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
    else $error("tx byte changed before it was taken");
  reserved_ins_a: assert property (
    EXEC_START_O |-> !(EXEC_CMD_O.hdr.ins[7:4] == 4'h1
      && !EXEC_CMD_O.hdr.ins[0]) && !(EXEC_CMD_O.hdr.ins inside
      {8'h2A, 8'hD0, 8'hD2, 8'hDE, 8'hC4, 8'hC6, 8'hC8, 8'hCA,
       8'hCC, 8'hB4, 8'hB6, 8'hB8, 8'hBA, 8'hBC}))
    else $error("reserved instruction was started");
  pend_len_a: assert property (PENDING_O |-> PEND_LEN_O != 8'h00)
    else $error("pending flagged with zero length");
  select_fix_a: assert property (
    EXEC_START_O && EXEC_CMD_O.hdr.ins == INS_SELECT |->
      {EXEC_CMD_O.hdr.p1, EXEC_CMD_O.hdr.p2, EXEC_CMD_O.hdr.p3}
      == 24'h000002)
    else $error("select started with wrong parameters");
endmodule

bind sad_top sad_top_sva chk (.REF_CLK_I, .ARST_N_I, .RX_VALID_I,
  .RX_READY_O, .TX_DATA_O, .TX_VALID_O, .TX_READY_I, .EXEC_START_O,
  .EXEC_CMD_O, .EXEC_DIN_VALID_O, .EXEC_RSP_READY_O, .PENDING_O,
  .PEND_LEN_O);

/* File: sim/sad_exec_model.sv */
// behavioural execution unit: sinks data, sources byte k = k, then done
// assumes the decoder's start/din/rsp handshake on the same clock
`timescale 1ns/1ps
module sad_exec_model
  import sad_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire sad_cmd_t cmd_i,
  input wire logic din_valid_i,
  input wire logic rsp_ready_i,
  input wire logic slow_i,
  input wire sad_sw_t sw_cfg_i,
  input wire logic [7:0] rlen_cfg_i,
  output logic [7:0] rsp_o,
  output logic rsp_valid_o,
  output logic done_o,
  output sad_sw_t sw_o,
  output logic [7:0] rlen_o
);
  logic [LEN_W-1:0] left;
  logic busy;
  logic tick;

  // done is a pulse: a held level would finish the next command early
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      left <= '0;
      busy <= 1'b0;
      tick <= 1'b0;
      rsp_o <= 8'h00;
      rsp_valid_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      tick <= !tick;
      done_o <= 1'b0;
      if (start_i) begin
        left <= cmd_i.len;
        busy <= 1'b1;
      end else if (busy && cmd_i.data_out && left != '0) begin
        if (rsp_valid_o && rsp_ready_i) begin
          left <= left - 1'b1;
          rsp_valid_o <= 1'b0;
          rsp_o <= ~rsp_o;
        end else if (!rsp_valid_o && (!slow_i || tick)) begin
          rsp_valid_o <= 1'b1;
          rsp_o <= 8'(cmd_i.len - left);
        end
      end else if (busy && cmd_i.data_in && left != '0) begin
        if (din_valid_i)
          left <= left - 1'b1;
      end else if (busy) begin
        done_o <= 1'b1;
        busy <= 1'b0;
      end
    end
  end

  assign sw_o = sw_cfg_i;
  assign rlen_o = rlen_cfg_i;
endmodule

/* File: sim/testbench.sv */
// self-checking bench: terminal side driven here, exec side by the model
// assumes the decoder answers every header with two status bytes
`timescale 1ns/1ps
module testbench;
  import sad_pkg::*;
  logic clk, rstn, rxv, rxr, txv, txr, st, dv, rv, rr, dn, pnd, slow;
  logic [7:0] rxd, txd, din, rsp, rlen, plen, rlcfg;
  sad_cmd_t cmd;
  sad_sw_t sw, swcfg;
  int err_count = 0;
  int samples_checked = 0;
  int starts = 0;
  int dins = 0;

  sad_top dut (.REF_CLK_I(clk), .ARST_N_I(rstn), .RX_DATA_I(rxd),
    .RX_VALID_I(rxv), .RX_READY_O(rxr), .TX_DATA_O(txd), .TX_VALID_O(txv),
    .TX_READY_I(txr), .EXEC_START_O(st), .EXEC_CMD_O(cmd),
    .EXEC_DIN_O(din), .EXEC_DIN_VALID_O(dv), .EXEC_RSP_I(rsp),
    .EXEC_RSP_VALID_I(rv), .EXEC_RSP_READY_O(rr), .EXEC_DONE_I(dn),
    .EXEC_SW_I(sw), .EXEC_RLEN_I(rlen), .PENDING_O(pnd),
    .PEND_LEN_O(plen));
  sad_exec_model exec (.clk_i(clk), .arst_n_i(rstn), .start_i(st),
    .cmd_i(cmd), .din_valid_i(dv), .rsp_ready_i(rr), .slow_i(slow),
    .sw_cfg_i(swcfg), .rlen_cfg_i(rlcfg), .rsp_o(rsp), .rsp_valid_o(rv),
    .done_o(dn), .sw_o(sw), .rlen_o(rlen));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (st === 1'b1) starts++;
  always @(posedge clk) if (dv === 1'b1) dins++;

  task automatic chk(input string nm, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // header, nin data bytes out; nout data bytes and two status bytes back
  task automatic run_cmd(input logic [39:0] h, input int nin, nout,
                         input logic [15:0] esw);
    int k;
    int n;
    int d0;
    logic [15:0] got;
    d0 = dins;
    for (k = 0; k < 5 + nin; k++) begin
      rxd <= k < 5 ? h[39-8*k -: 8] : 8'(k);
      rxv <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (rxr !== 1'b1 && n < 3000);
      chk("rx take", 16'h0001, {15'h0, rxr});
    end
    rxv <= 1'b0;
    n = 0;
    k = 0;
    while (k < nout + 2 && n < 20000) begin
      txr <= !slow || n[1];
      @(posedge clk);
      n++;
      if (txv === 1'b1 && txr === 1'b1) begin
        if (k < nout)
          chk("data", 16'(k[7:0]), {8'h00, txd});
        got = {got[7:0], txd};
        k++;
      end
    end
    chk("tx count", 16'(nout + 2), 16'(k));
    chk("status", esw, got);
    chk("din count", 16'(nin), 16'(dins - d0));
    if (nin > 0)
      chk("din", 16'(4 + nin), {8'h00, din});
  endtask

  task automatic t_pending();
    rlcfg <= 8'h1A;
    run_cmd(40'hA0A4000002, 2, 0, 16'h9F1A);
    chk("pending", 16'h0001, {15'h0, pnd});
    chk("pend len", 16'h001A, {8'h00, plen});
  endtask

  task automatic t_foreign();
    int s;
    s = starts;
    run_cmd(40'h12B0000004, 0, 0, SW_ERR_CLA);
    chk("starts", 16'(s), 16'(starts));
    chk("pending", 16'h0001, {15'h0, pnd});
    chk("pend len", 16'h001A, {8'h00, plen});
  endtask

  task automatic t_fetch();
    rlcfg <= 8'h00;
    run_cmd(40'hA0C000001B, 0, 0, SW_ERR_LEN);
    run_cmd(40'hA0C0000000, 0, 0, SW_ERR_LEN);
    chk("pending", 16'h0001, {15'h0, pnd});
    run_cmd(40'hA0C000001A, 0, 26, SW_OK);
    chk("pending", 16'h0000, {15'h0, pnd});
    run_cmd(40'hA0C0000004, 0, 0, SW_ERR_NODATA);
  endtask

  // receiver stalls half the time, matching the slow model, while 256 bytes stream out
  task automatic t_read256();
    slow <= 1'b1;
    run_cmd(40'hA0B0FFFF00, 0, 256, SW_OK);
    chk("offset", 16'hFFFF, cmd.offset);
    chk("len", 16'h0100, 16'(cmd.len));
    slow <= 1'b0;
  endtask

  task automatic t_write0();
    run_cmd(40'hA0D6000100, 0, 0, SW_OK);
    chk("offset", 16'h0001, cmd.offset);
    chk("len", 16'h0000, 16'(cmd.len));
  endtask

  task automatic t_reserved();
    logic [7:0] rs[22] = '{8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1A,
      8'h1C, 8'h1E, 8'h2A, 8'hD0, 8'hD2, 8'hDE, 8'hC4, 8'hC6, 8'hC8,
      8'hCA, 8'hCC, 8'hB4, 8'hB6, 8'hB8, 8'hBA, 8'hBC};
    int s;
    s = starts;
    foreach (rs[i])
      run_cmd({8'hA0, rs[i], 24'h0}, 0, 0, SW_ERR_INS);
    chk("starts", 16'(s), 16'(starts));
  endtask

  task automatic t_fixed();
    run_cmd(40'hA020000108, 8, 0, SW_OK);
    run_cmd(40'hA024000210, 16, 0, SW_OK);
    run_cmd(40'hA026000108, 8, 0, SW_OK);
    run_cmd(40'hA028000108, 8, 0, SW_OK);
    run_cmd(40'hA02C000010, 16, 0, SW_OK);
    run_cmd(40'hA02C000210, 16, 0, SW_OK);
    run_cmd(40'hA004000000, 0, 0, SW_OK);
    run_cmd(40'hA044000000, 0, 0, SW_OK);
    run_cmd(40'hA0FA000000, 0, 0, SW_OK);
    run_cmd(40'hA032000003, 3, 0, SW_OK);
    run_cmd(40'hA088000010, 16, 0, SW_OK);
    run_cmd(40'hA0DC050403, 3, 0, SW_OK);
    run_cmd(40'hA0B2050403, 0, 3, SW_OK);
    run_cmd(40'hA0A2001002, 2, 0, SW_OK);
    run_cmd(40'hA0F2000004, 0, 4, SW_OK);
  endtask

  task automatic t_badpar();
    run_cmd(40'hA020000107, 0, 0, SW_ERR_LEN);
    run_cmd(40'hA026010108, 0, 0, SW_ERR_PAR);
    run_cmd(40'hA02C000310, 0, 0, SW_ERR_PAR);
  endtask

  initial begin
    rstn = 1'b0;
    rxv = 1'b0;
    rxd = 8'h00;
    txr = 1'b0;
    slow = 1'b0;
    swcfg = SW_OK;
    rlcfg = 8'h00;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    do @(posedge clk); while (rxr !== 1'b1);
    t_pending();
    t_foreign();
    t_fetch();
    t_read256();
    t_write0();
    t_reserved();
    t_fixed();
    t_badpar();
    final_report();
  end

  // whole run needs well under 10000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    $display("unexpected watchdog expected finish seen hang");
    final_report();
  end
endmodule
